// ---- design/adc_conversion_control.sv ----
// Register file, clock divider and sample sequencer of the converter
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_control (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    // Start and wake requests from system logic
    input  wire logic                      start_request,
    input  wire logic                      wake_request,
    // Result from converter and accumulator
    input  wire conv_ctl_pkg::result_s     result,
    // Analog front end control
    output conv_ctl_pkg::analog_ctl_s      analog_ctl,
    output logic                           conv_clock_tick,
    output logic                           busy,
    // Interrupt
    output logic                           irq
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    function automatic logic [7:0] div_limit(input logic [2:0] code);
        div_limit = 8'((9'h002 << code) - 9'h001);
    endfunction : div_limit

    function automatic logic [8:0] startup_ticks(input logic [2:0] code);
        if (code == 3'h0 || code > 3'h5)
            startup_ticks = 9'h000;
        else
            startup_ticks = 9'(conv_ctl_pkg::STARTUP_UNIT << (code - 3'h1));
    endfunction : startup_ticks

    function automatic logic window_hit(input logic [2:0] mode,
                                        input logic [15:0] val,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
        case (mode)
            conv_ctl_pkg::WIN_BELOW:   window_hit = val < lo;
            conv_ctl_pkg::WIN_ABOVE:   window_hit = val > hi;
            conv_ctl_pkg::WIN_INSIDE:  window_hit = (val > lo) && (val < hi);
            conv_ctl_pkg::WIN_OUTSIDE: window_hit = (val < lo) || (val > hi);
            default:                   window_hit = 1'b0;
        endcase
    endfunction : window_hit

    typedef enum {S_IDLE, S_INIT, S_GAP, S_SAMPLE, S_HOLD} seq_e;

    // ************************************************************
    // Registers
    // ************************************************************
    logic        enable;
    logic        sample_cap_select;
    logic [1:0]  reference_choice;
    logic [2:0]  converter_clock_divider;
    logic [2:0]  startup_delay;
    logic        auto_delay_variation;
    logic [3:0]  inter_sample_delay;
    logic [2:0]  window_mode;
    logic [4:0]  sample_length;
    logic [4:0]  input_select;
    logic [1:0]  int_mask;
    logic [1:0]  int_status;
    logic [15:0] window_low_threshold;
    logic [15:0] window_high_threshold;
    logic [15:0] last_result;
    logic [7:0]  div_count;
    logic [8:0]  phase_count;
    logic        need_init;
    logic        had_sample;
    seq_e        state;
    seq_e        next_state;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire         access    = psel & penable & pready;
    wire [7:0]   reg_idx   = {2'b00, paddr[7:2]};
    wire         wr        = access & pwrite;
    wire         rd        = access & ~pwrite;
    wire         wr_enable = wr & (reg_idx == conv_ctl_pkg::IDX_ENABLE);
    wire         wr_refclk = wr & (reg_idx == conv_ctl_pkg::IDX_REF_CLK);
    wire         wr_delay  = wr & (reg_idx == conv_ctl_pkg::IDX_DELAY);
    wire         wr_win    = wr & (reg_idx == conv_ctl_pkg::IDX_WIN_MODE);
    wire         wr_slen   = wr & (reg_idx == conv_ctl_pkg::IDX_SAMP_LEN);
    wire         wr_insel  = wr & (reg_idx == conv_ctl_pkg::IDX_INPUT_SEL);
    wire         wr_cmd    = wr & (reg_idx == conv_ctl_pkg::IDX_COMMAND);
    wire         wr_mask   = wr & (reg_idx == conv_ctl_pkg::IDX_INT_MASK);
    wire         wr_stat   = wr & (reg_idx == conv_ctl_pkg::IDX_INT_STATUS);
    wire         wr_low    = wr & (reg_idx == conv_ctl_pkg::IDX_WIN_LOW);
    wire         wr_high   = wr & (reg_idx == conv_ctl_pkg::IDX_WIN_HIGH);
    wire         rd_result = rd & (reg_idx == conv_ctl_pkg::IDX_RESULT);
    logic [31:0] read_mux;
    logic        mapped;

    always_comb begin
        mapped   = 1'b1;
        read_mux = 32'h0000_0000;
        case (reg_idx)
            conv_ctl_pkg::IDX_ENABLE:     read_mux[0] = enable;
            conv_ctl_pkg::IDX_REF_CLK:    read_mux[7:0] = {1'b0,
                sample_cap_select, reference_choice, 1'b0,
                converter_clock_divider};
            conv_ctl_pkg::IDX_DELAY:      read_mux[7:0] = {startup_delay,
                auto_delay_variation, inter_sample_delay};
            conv_ctl_pkg::IDX_WIN_MODE:   read_mux[2:0] = window_mode;
            conv_ctl_pkg::IDX_SAMP_LEN:   read_mux[4:0] = sample_length;
            conv_ctl_pkg::IDX_INPUT_SEL:  read_mux[4:0] = input_select;
            conv_ctl_pkg::IDX_COMMAND:    read_mux[0] = busy;
            conv_ctl_pkg::IDX_INT_MASK:   read_mux[1:0] = int_mask;
            conv_ctl_pkg::IDX_INT_STATUS: read_mux[1:0] = int_status;
            conv_ctl_pkg::IDX_RESULT:     read_mux[15:0] = last_result;
            conv_ctl_pkg::IDX_WIN_LOW:    read_mux[15:0] = window_low_threshold;
            conv_ctl_pkg::IDX_WIN_HIGH:   read_mux[15:0] = window_high_threshold;
            default:                      mapped = 1'b0;
        endcase
    end

    // One wait state so that read data and response come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= read_mux;
            pslverr <= psel & penable & ~pready & ~mapped;
        end
    end

    // ************************************************************
    // Converter clock divider
    // ************************************************************
    wire [7:0] div_top  = div_limit(converter_clock_divider);
    wire       div_wrap = div_count >= div_top;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count       <= 8'h00;
            conv_clock_tick <= 1'b0;
        end else begin
            div_count       <= div_wrap ? 8'h00 : div_count + 8'h01;
            conv_clock_tick <= div_wrap;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    wire [8:0] init_len   = startup_ticks(startup_delay);
    wire [8:0] gap_len    = {5'h00, inter_sample_delay};
    wire [8:0] sample_len = conv_ctl_pkg::BASE_SAMPLE
                          + {4'h0, sample_length};
    wire       start_go   = enable & (start_request | wr_cmd & pwdata[0]);
    wire       phase_end  = conv_clock_tick & (phase_count
                          == ((state == S_INIT) ? init_len - 9'h001 :
                              (state == S_GAP)  ? gap_len - 9'h001 :
                                                  sample_len - 9'h001));
    wire       got_result = (state == S_HOLD) & result.valid;
    wire       conv_end   = got_result & result.last;
    wire       hit        = window_hit(window_mode, result.value,
                                       window_low_threshold,
                                       window_high_threshold);
    wire       gap_or_smp = (had_sample && gap_len != 9'h000);
    wire       ref_to_int = wr_refclk
                          && pwdata[conv_ctl_pkg::REF_LSB +: 2]
                             == conv_ctl_pkg::REF_INTERNAL
                          && reference_choice != conv_ctl_pkg::REF_INTERNAL;

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:
                if (start_go) begin
                    if (need_init && init_len != 9'h000)
                        next_state = S_INIT;
                    else if (gap_or_smp)
                        next_state = S_GAP;
                    else
                        next_state = S_SAMPLE;
                end
            S_INIT:   if (phase_end) next_state = S_SAMPLE;
            S_GAP:    if (phase_end) next_state = S_SAMPLE;
            S_SAMPLE: if (phase_end) next_state = S_HOLD;
            S_HOLD:
                if (conv_end)
                    next_state = S_IDLE;
                else if (got_result)
                    next_state = (gap_len != 9'h000) ? S_GAP : S_SAMPLE;
            default:  next_state = S_IDLE;
        endcase
        if (!enable)
            next_state = S_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= S_IDLE;
            phase_count <= 9'h000;
            busy        <= 1'b0;
        end else begin
            state       <= next_state;
            phase_count <= (next_state != state) ? 9'h000 :
                           phase_count + {8'h00, conv_clock_tick};
            busy        <= next_state != S_IDLE;
        end
    end

    // Start-up delay is owed after enable, internal reference or wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            need_init  <= 1'b1;
            had_sample <= 1'b0;
        end else begin
            if ((wr_enable && pwdata[0] && !enable) || ref_to_int
                || wake_request)
                need_init <= 1'b1;
            else if (state == S_INIT || (state == S_IDLE && start_go))
                need_init <= 1'b0;
            if (!enable || need_init)
                had_sample <= 1'b0;
            else if (got_result)
                had_sample <= 1'b1;
        end
    end

    // ************************************************************
    // Software registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable                  <= 1'b0;
            sample_cap_select       <= 1'b0;
            reference_choice        <= 2'h0;
            converter_clock_divider <= 3'h0;
            window_mode             <= 3'h0;
            sample_length           <= 5'h00;
            input_select            <= 5'h00;
            int_mask                <= 2'h0;
            window_low_threshold    <= conv_ctl_pkg::THR_RESET;
            window_high_threshold   <= conv_ctl_pkg::THR_RESET;
        end else begin
            if (wr_enable) enable <= pwdata[0];
            if (wr_refclk) begin
                sample_cap_select       <= pwdata[conv_ctl_pkg::SAMPLE_CAP_BIT];
                reference_choice        <= pwdata[conv_ctl_pkg::REF_LSB +: 2];
                converter_clock_divider <= pwdata[conv_ctl_pkg::DIV_LSB +: 3];
            end
            if (wr_win)   window_mode   <= pwdata[2:0];
            if (wr_slen)  sample_length <= pwdata[4:0];
            if (wr_insel) input_select  <= pwdata[4:0];
            if (wr_mask)  int_mask      <= pwdata[1:0];
            if (wr_low)   window_low_threshold  <= pwdata[15:0];
            if (wr_high)  window_high_threshold <= pwdata[15:0];
        end
    end

    // A software write of the delay register wins over the auto step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_delay        <= 3'h0;
            auto_delay_variation <= 1'b0;
            inter_sample_delay   <= 4'h0;
        end else if (wr_delay) begin
            startup_delay        <= pwdata[conv_ctl_pkg::STARTUP_LSB +: 3];
            auto_delay_variation <= pwdata[conv_ctl_pkg::AUTO_DELAY_BIT];
            inter_sample_delay   <= pwdata[conv_ctl_pkg::GAP_LSB +: 4];
        end else if (got_result && auto_delay_variation) begin
            inter_sample_delay   <= inter_sample_delay + 4'h1;
        end
    end

    // ************************************************************
    // Flags, result and interrupt
    // ************************************************************
    wire [1:0] flag_set = {conv_end & hit, conv_end};
    wire [1:0] flag_clr = (wr_stat ? pwdata[1:0] : 2'h0)
                        | {2{rd_result}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status  <= 2'h0;
            last_result <= 16'h0000;
            irq         <= 1'b0;
        end else begin
            int_status  <= flag_set | (int_status & ~flag_clr);
            if (conv_end)
                last_result <= result.value;
            irq         <= |(int_status & int_mask);
        end
    end

    // Select changes only reach the mux between conversions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ctl <= '0;
        end else begin
            analog_ctl.sample_cap_select <= sample_cap_select;
            analog_ctl.reference_choice  <= reference_choice;
            if (next_state == S_IDLE)
                analog_ctl.input_select  <= input_select;
            analog_ctl.sampling          <= next_state == S_SAMPLE;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Own tally of sampling ticks, kept apart from the phase counter
    logic [8:0] smp_ticks;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            smp_ticks <= 9'h000;
        else if (state != S_SAMPLE)
            smp_ticks <= 9'h000;
        else
            smp_ticks <= smp_ticks + {8'h00, conv_clock_tick};
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    div_fastest_a: assert property ((conv_clock_tick
        && converter_clock_divider == 3'h0
        && !wr_refclk) |=> !conv_clock_tick ##1
        conv_clock_tick) else $error("divide by two period wrong");
    ref_follow_a: assert property (##1 analog_ctl.reference_choice
        == $past(reference_choice)) else $error("reference not driven");
    cap_follow_a: assert property (##1 analog_ctl.sample_cap_select
        == $past(sample_cap_select)) else $error("capacitor not driven");
    init_length_a: assert property ((state == S_INIT)
        |-> phase_count < init_len) else $error("start-up delay overrun");
    gap_open_a: assert property ((state == S_GAP) |-> (phase_count
        < gap_len) && !analog_ctl.sampling)
        else $error("gap too long or cap closed");
    auto_step_a: assert property ((got_result && auto_delay_variation
        && !wr_delay) |=> inter_sample_delay
        == 4'($past(inter_sample_delay) + 4'h1))
        else $error("delay not stepped");
    win_flag_a: assert property ((conv_end && !hit
        && !int_status[conv_ctl_pkg::FLAG_WINDOW])
        |=> !int_status[conv_ctl_pkg::FLAG_WINDOW])
        else $error("window flag without match");
    win_set_a: assert property ((conv_end && hit) |=>
        int_status[conv_ctl_pkg::FLAG_WINDOW]) else $error("window missed");
    sample_len_a: assert property ((state == S_SAMPLE
        && next_state == S_HOLD) |-> conv_clock_tick
        && smp_ticks == sample_len - 9'h001)
        else $error("sampling length wrong");
    mux_hold_a: assert property ((state != S_IDLE
        && next_state != S_IDLE) |=> $stable(analog_ctl.input_select))
        else $error("input changed mid conversion");
    irq_level_a: assert property (##1 irq
        == $past(|(int_status & int_mask))) else $error("irq mismatch");

endmodule : adc_conversion_control

`default_nettype wire

// ---- design/conv_ctl_pkg.sv ----
// Constants and types shared by the converter control block
package conv_ctl_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_ENABLE      = 8'h00;
    localparam logic [7:0] IDX_REF_CLK     = 8'h02;
    localparam logic [7:0] IDX_DELAY       = 8'h03;
    localparam logic [7:0] IDX_WIN_MODE    = 8'h04;
    localparam logic [7:0] IDX_SAMP_LEN    = 8'h05;
    localparam logic [7:0] IDX_INPUT_SEL   = 8'h06;
    localparam logic [7:0] IDX_COMMAND     = 8'h08;
    localparam logic [7:0] IDX_INT_MASK    = 8'h0A;
    localparam logic [7:0] IDX_INT_STATUS  = 8'h0B;
    localparam logic [7:0] IDX_RESULT      = 8'h10;
    localparam logic [7:0] IDX_WIN_LOW     = 8'h12;
    localparam logic [7:0] IDX_WIN_HIGH    = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int SAMPLE_CAP_BIT  = 6;
    localparam int REF_LSB         = 4;
    localparam int DIV_LSB         = 0;
    localparam int STARTUP_LSB     = 5;
    localparam int AUTO_DELAY_BIT  = 4;
    localparam int GAP_LSB         = 0;
    localparam int FLAG_READY      = 0;
    localparam int FLAG_WINDOW     = 1;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [15:0] THR_RESET = 16'h0000;

    // ************************************************************
    // Codes and timing
    // ************************************************************
    localparam logic [1:0] REF_INTERNAL  = 2'h0;
    localparam logic [2:0] WIN_NONE      = 3'h0;
    localparam logic [2:0] WIN_BELOW     = 3'h1;
    localparam logic [2:0] WIN_ABOVE     = 3'h2;
    localparam logic [2:0] WIN_INSIDE    = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE   = 3'h4;
    localparam logic [8:0] BASE_SAMPLE   = 9'h002;
    localparam logic [8:0] STARTUP_UNIT  = 9'h010;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [15:0] value;
    } result_s;

    typedef struct packed {
        logic       sample_cap_select;
        logic [1:0] reference_choice;
        logic [4:0] input_select;
        logic       sampling;
    } analog_ctl_s;

endpackage : conv_ctl_pkg

// ---- sim/front_end_model.sv ----
// Behavioural analog front end that answers each finished sample
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // Control from the block and answer setup from the bench
    input  wire conv_ctl_pkg::analog_ctl_s analog_ctl,
    input  wire logic [15:0]               answer_value,
    input  wire logic [5:0]                lag,
    // Answer back to the block
    output var conv_ctl_pkg::result_s      result
);
    logic       was_sampling;
    logic [5:0] wait_n;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            was_sampling <= 1'b0;
            wait_n       <= 6'h00;
            result       <= '{1'b0, 1'b0, 16'hA5A5};
        end else begin
            was_sampling <= analog_ctl.sampling;
            result.valid <= 1'b0;
            result.last  <= 1'b0;
            // Value is not held between answers, so a stale read shows up
            result.value <= ~result.value;
            if (was_sampling && !analog_ctl.sampling) begin
                wait_n <= lag;
            end else if (wait_n == 6'h01) begin
                result <= '{1'b1, 1'b1, answer_value};
                wait_n <= 6'h00;
            end else if (wait_n != 6'h00) begin
                wait_n <= wait_n - 6'h01;
            end
        end
    end
endmodule : front_end_model
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic start_request = 0, wake_request = 0;
    logic pready, pslverr, busy, irq, conv_clock_tick, er, e;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [15:0] answer_value = 16'h0000;
    logic [5:0]  lag = 6'h01;
    logic [15:0] vals [5] = '{16'h00FF, 16'h0100, 16'h0150, 16'h0200, 16'h0201};
    conv_ctl_pkg::result_s     result;
    conv_ctl_pkg::analog_ctl_s analog_ctl;
    int mismatches = 0, checked = 0, samp_n = 0, pre_n = 0, g, n;

    always #20 pclk = ~pclk;

    adc_conversion_control u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .start_request(start_request),
        .wake_request(wake_request), .result(result),
        .analog_ctl(analog_ctl), .conv_clock_tick(conv_clock_tick),
        .busy(busy), .irq(irq));
    front_end_model u_front (.pclk(pclk), .presetn(presetn),
        .analog_ctl(analog_ctl), .answer_value(answer_value), .lag(lag),
        .result(result));

    // Cycles spent waiting before the first sample, and sampling
    always @(posedge pclk) begin
        if (start_request) begin
            samp_n <= 0;
            pre_n  <= 0;
        end else if (busy === 1'b1 && analog_ctl.sampling === 1'b1) begin
            samp_n <= samp_n + 1;
        end else if (busy === 1'b1 && samp_n == 0) begin
            pre_n <= pre_n + 1;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= idx << 2;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task go(input logic [15:0] v, input logic [5:0] d);
        answer_value <= v;
        lag          <= d;
        @(posedge pclk);
        start_request <= 1'b1;
        @(posedge pclk);
        start_request <= 1'b0;
        @(posedge pclk);
    endtask : go

    task fin;
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge pclk);
            n++;
        end
        repeat (3) @(posedge pclk);
    endtask : fin

    task tick_gap;
        n = 0;
        g = 0;
        while (conv_clock_tick !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        do begin
            @(posedge pclk);
            g++;
        end while (conv_clock_tick !== 1'b1 && g < 600);
    endtask : tick_gap

    function automatic logic win(input int m, input logic [15:0] v);
        case (m)
            1: return v < 16'h0100;
            2: return v > 16'h0200;
            3: return v > 16'h0100 && v < 16'h0200;
            4: return v < 16'h0100 || v > 16'h0200;
            default: return 1'b0;
        endcase
    endfunction : win

    task wrap_up;
        $display("%0t checked %0d mismatches %0d", $time, checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        wrap_up;
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 2; i <= 6; i++) begin
            apb(1'b0, i[7:0], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b1, conv_ctl_pkg::IDX_REF_CLK, 32'hFF);
        apb(1'b0, conv_ctl_pkg::IDX_REF_CLK, 32'h0);
        chk(rd, 32'h77);
        chk({analog_ctl.sample_cap_select, analog_ctl.reference_choice}, 7);
        apb(1'b0, 8'h07, 32'h0);
        chk(er, 1'b1);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, conv_ctl_pkg::IDX_REF_CLK, c);
            tick_gap;
            tick_gap;
            chk(g, 2 << c);
        end
        $display("%0t test registers and divider done", $time);
        apb(1'b1, conv_ctl_pkg::IDX_REF_CLK, 32'h0);
        apb(1'b1, conv_ctl_pkg::IDX_SAMP_LEN, 32'h3);
        apb(1'b1, conv_ctl_pkg::IDX_ENABLE, 32'h1);
        apb(1'b1, conv_ctl_pkg::IDX_INT_MASK, 32'h2);
        apb(1'b1, conv_ctl_pkg::IDX_WIN_LOW, 32'h100);
        apb(1'b1, conv_ctl_pkg::IDX_WIN_HIGH, 32'h200);
        for (int m = 0; m < 5; m++) begin
            for (int k = 0; k < 5; k++) begin
                apb(1'b1, conv_ctl_pkg::IDX_WIN_MODE, m);
                go(vals[k], 6'h01);
                fin;
                e = win(m, vals[k]);
                chk(irq, e);
                chk(samp_n > 8 && samp_n <= 11, 1'b1);
                apb(1'b0, conv_ctl_pkg::IDX_INT_STATUS, 32'h0);
                chk(rd[1:0], {e, 1'b1});
                apb(1'b1, conv_ctl_pkg::IDX_INT_STATUS, 32'h3);
            end
        end
        $display("%0t test window done", $time);
        apb(1'b1, conv_ctl_pkg::IDX_DELAY, 32'h20);
        @(posedge pclk);
        wake_request <= 1'b1;
        @(posedge pclk);
        wake_request <= 1'b0;
        go(16'h0150, 6'h01);
        fin;
        chk(pre_n >= 30 && pre_n <= 37, 1'b1);
        apb(1'b1, conv_ctl_pkg::IDX_ENABLE, 32'h0);
        apb(1'b1, conv_ctl_pkg::IDX_ENABLE, 32'h1);
        go(16'h0150, 6'h01);
        fin;
        chk(pre_n >= 30 && pre_n <= 37, 1'b1);
        go(16'h0150, 6'h01);
        fin;
        chk(pre_n < 6, 1'b1);
        $display("%0t test start-up delay done", $time);
        apb(1'b1, conv_ctl_pkg::IDX_INPUT_SEL, 32'h5);
        repeat (2) @(posedge pclk);
        chk(analog_ctl.input_select, 5'h05);
        go(16'h0150, 6'd40);
        apb(1'b1, conv_ctl_pkg::IDX_INPUT_SEL, 32'h1F);
        chk({busy, analog_ctl.input_select}, 6'h25);
        fin;
        chk(analog_ctl.input_select, 5'h1F);
        apb(1'b1, conv_ctl_pkg::IDX_DELAY, 32'h1F);
        go(16'h0150, 6'h01);
        fin;
        chk(pre_n >= 28 && pre_n <= 31, 1'b1);
        apb(1'b0, conv_ctl_pkg::IDX_DELAY, 32'h0);
        chk(rd, 32'h10);
        apb(1'b1, conv_ctl_pkg::IDX_COMMAND, 32'h1);
        apb(1'b0, conv_ctl_pkg::IDX_COMMAND, 32'h0);
        chk(rd, 32'h1);
        fin;
        apb(1'b0, conv_ctl_pkg::IDX_RESULT, 32'h0);
        chk(rd, 32'h150);
        apb(1'b0, conv_ctl_pkg::IDX_INT_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("%0t test input select and delay variation done", $time);
        wrap_up;
    end
endmodule : tb
`default_nettype wire
